// ### dv/adcs_afe_model.sv
// Purpose: analog front end that feeds the converter sequencer
// Assumes: bench sets level before each conversion
// Notes:   outside a conversion the value is a pattern, not a hold
`timescale 1ns/1ps

module adcs_afe_model (
  // clock
  input  wire logic       clk,
  // sequencer side
  input  wire logic [3:0] channel_select,
  input  wire logic       analog_input_disable,
  input  wire logic       sample_active,
  input  wire logic [7:0] level,
  // converted value
  output logic      [7:0] conv_data_i
);
  logic [7:0] junk_ff = 8'h00;
  logic       live;

  // pattern flips bits 7:1 every cycle, bit 0 stays low, so a stale sample never matches
  always_ff @(posedge clk) begin
    junk_ff <= ~junk_ff ^ 8'h01;
  end

  // each channel gives its own value, disabled inputs give junk
  assign live        = sample_active & ~analog_input_disable;
  assign conv_data_i = live ? level ^ {channel_select, channel_select}
                            : junk_ff;
endmodule

// ### dv/tb_adcs_top.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: register port answers one cycle after the read strobe
// Notes:   read results are checked from a queue by a monitor
`timescale 1ns/1ps
`include "adcs_regs_regs.svh"

module tb_adcs_top;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       low_power_i = 1'b0;
  logic [7:0] level = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] conv_data_i;
  logic [3:0] channel_select;
  logic       analog_input_disable;
  logic       ladder_on;
  logic       sample_active;
  logic       conversion_done_irq;
  logic [7:0] exp_q[$];
  logic       rd_seen = 1'b0;
  int         failures = 0;
  int         n_tests = 0;
  int         cycles = 0;
  localparam int CYC [8] = '{39, 39, 78, 156, 312, 624, 1248, 39};

  always #10 clk = ~clk;

  adcs_top uut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .low_power_i(low_power_i),
    .conv_data_i(conv_data_i), .channel_select(channel_select),
    .analog_input_disable(analog_input_disable), .ladder_on(ladder_on),
    .sample_active(sample_active),
    .conversion_done_irq(conversion_done_irq));

  adcs_afe_model afe (.clk(clk), .channel_select(channel_select),
    .analog_input_disable(analog_input_disable),
    .sample_active(sample_active), .level(level),
    .conv_data_i(conv_data_i));

  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one bus cycle; every strobe is set each call, so none doubles up
  task automatic bus(logic w, logic r, logic [7:0] a, logic [7:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic idle(int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen)
      chk("reg_rdata", reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      test_done();
    end
  end

  // one full conversion, checked at the exact finishing cycle
  task automatic convert(logic [2:0] code, logic lad, logic msk);
    logic [3:0] ch;
    int         n;
    ch = 4'($urandom_range(5));
    n = CYC[code];
    level <= 8'($urandom);
    wr(`ADCS_OFF_IRQ_MASK, {7'h00, msk});
    wr(`ADCS_OFF_CTRL2, {2'b11, lad, 1'b1, code, 1'b0});
    rd(`ADCS_OFF_CTRL2, {2'b00, lad, 1'b1, code, 1'b0});
    wr(`ADCS_OFF_CTRL1, {4'hA, ch});
    idle(2);
    chk("sample_active", {7'h00, sample_active}, 8'h01);
    chk("ladder_on", {7'h00, ladder_on}, 8'h01);
    chk("channel", {4'h0, channel_select}, {4'h0, ch});
    rd(`ADCS_OFF_CTRL1, {4'h2, ch});
    rd(`ADCS_OFF_STATUS, 8'h10);
    idle(n - 2);
    chk("irq early", {7'h00, conversion_done_irq}, 8'h00);
    idle(1);
    chk("irq", {7'h00, conversion_done_irq}, {7'h00, msk});
    chk("busy end", {7'h00, sample_active}, 8'h00);
    rd(`ADCS_OFF_STATUS, 8'h20);
    rd(`ADCS_OFF_RESULT, level ^ {ch, ch});
    idle(1);
    rd(`ADCS_OFF_STATUS, 8'h00);
    rd(`ADCS_OFF_IRQ_STAT, 8'h01);
    wr(`ADCS_OFF_IRQ_STAT, 8'h01);
    idle(2);
    chk("irq clear", {7'h00, conversion_done_irq}, 8'h00);
    chk("ladder idle", {7'h00, ladder_on}, {7'h00, lad});
    rd(`ADCS_OFF_IRQ_STAT, 8'h00);
  endtask

  initial begin
    logic [7:0] old;
    void'($urandom(51659));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    // reset values and an unmapped place
    chk("disable", {7'h00, analog_input_disable}, 8'h01);
    rd(`ADCS_OFF_CTRL1, 8'h10);
    rd(`ADCS_OFF_CTRL2, 8'h00);
    rd(`ADCS_OFF_STATUS, 8'h00);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    // every time code, reserved ones included, mask on and off
    for (int c = 0; c < 8; c++) begin
      convert(3'(c), 1'($urandom), 1'(c % 2 == 0));
    end
    // restart before the result is read keeps the old result
    old = level ^ 8'h33;
    wr(`ADCS_OFF_CTRL2, 8'h10);
    wr(`ADCS_OFF_CTRL1, 8'hA3);
    idle(45);
    level <= ~level;
    wr(`ADCS_OFF_CTRL1, 8'hA3);
    idle(2);
    rd(`ADCS_OFF_STATUS, 8'h10);
    rd(`ADCS_OFF_RESULT, old);
    idle(45);
    rd(`ADCS_OFF_RESULT, ~old);
    // low power aborts and locks the control registers
    wr(`ADCS_OFF_CTRL2, 8'h1C);
    wr(`ADCS_OFF_CTRL1, 8'hA5);
    idle(5);
    low_power_i <= 1'b1;
    idle(3);
    wr(`ADCS_OFF_CTRL1, 8'h25);
    wr(`ADCS_OFF_CTRL2, 8'h3C);
    rd(`ADCS_OFF_CTRL1, 8'h10);
    rd(`ADCS_OFF_CTRL2, 8'h00);
    rd(`ADCS_OFF_STATUS, 8'h00);
    idle(1);
    chk("lp disable", {7'h00, analog_input_disable}, 8'h01);
    chk("lp channel", {4'h0, channel_select}, 8'h00);
    low_power_i <= 1'b0;
    idle(80);
    rd(`ADCS_OFF_STATUS, 8'h00);
    // done events of the restart pair stay sticky through low power
    rd(`ADCS_OFF_IRQ_STAT, 8'h01);
    idle(3);
    test_done();
  end
endmodule

// ### hw/adcs_pkg.sv
// Purpose: types shared by the converter sequencer files
// Assumes: nothing beyond the register header
// Notes:   field layouts follow the control registers bit for bit
package adcs_pkg;

  // control register one
  typedef struct packed {
    logic       start;
    logic       fix6;
    logic       fix5;
    logic       ain_dis;
    logic [3:0] chan;
  } adcs_ctrl1_t;

  // control register two
  typedef struct packed {
    logic [1:0] undef;
    logic       ladder;
    logic       fix4;
    logic [2:0] ctime;
    logic       fix0;
  } adcs_ctrl2_t;

  // sequencer states, one-hot
  typedef enum logic [1:0] {
    ADCS_IDLE = 2'b01,
    ADCS_CONV = 2'b10
  } adcs_state_t;

endpackage

// ### hw/adcs_regs_regs.svh
// Purpose: register map, reset values and timing counts of the converter
// Assumes: 8-bit register port, byte-wide registers
// Notes:   definitions only
`ifndef ADCS_REGS_REGS_SVH
`define ADCS_REGS_REGS_SVH

// register offsets
`define ADCS_OFF_CTRL1     8'h0E
`define ADCS_OFF_CTRL2     8'h0F
`define ADCS_OFF_RESULT    8'h20
`define ADCS_OFF_STATUS    8'h21
`define ADCS_OFF_IRQ_STAT  8'h30
`define ADCS_OFF_IRQ_MASK  8'h31

// reset values
`define ADCS_CTRL1_RST     8'h10
`define ADCS_CTRL2_RST     8'h00
`define ADCS_BYTE_ZERO     8'h00

// status register bit positions
`define ADCS_STAT_EOC_BIT  5
`define ADCS_STAT_BUSY_BIT 4

// interrupt status bit of the conversion-done event
`define ADCS_IRQ_DONE_BIT  0

// conversion time codes and their counts in system clock cycles
`define ADCS_CT_W          11
`define ADCS_CODE_39       3'h0
`define ADCS_CODE_78       3'h2
`define ADCS_CODE_156      3'h3
`define ADCS_CODE_312      3'h4
`define ADCS_CODE_624      3'h5
`define ADCS_CODE_1248     3'h6
`define ADCS_CYC_39        11'h027
`define ADCS_CYC_78        11'h04E
`define ADCS_CYC_156       11'h09C
`define ADCS_CYC_312       11'h138
`define ADCS_CYC_624       11'h270
`define ADCS_CYC_1248      11'h4E0
`define ADCS_CNT_ZERO      11'h000
`define ADCS_CNT_ONE       11'h001

// highest channel code that names a real input
`define ADCS_CHAN_MAX      4'h5

`endif

// ### hw/adcs_timer.sv
// Purpose: down counter that times one conversion
// Assumes: ticks stable in the load cycle
// Notes:   done pulses ticks cycles after the load edge
`timescale 1ns/1ps
`include "adcs_regs_regs.svh"

module adcs_timer (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // control
  input  wire logic                   load,
  input  wire logic                   abort,
  input  wire logic [`ADCS_CT_W-1:0]  ticks,
  // result
  output logic                        done
);

  logic [`ADCS_CT_W-1:0] cnt_ff;
  logic [`ADCS_CT_W-1:0] nxt_cnt;
  logic                  nxt_done;
  logic                  running;

  // count runs while non-zero; abort beats load
  assign running  = (cnt_ff != `ADCS_CNT_ZERO);
  assign nxt_cnt  = abort   ? `ADCS_CNT_ZERO :
                    load    ? ticks :
                    running ? cnt_ff - `ADCS_CNT_ONE : cnt_ff;
  assign nxt_done = !abort && !load && (cnt_ff == `ADCS_CNT_ONE);

  // state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= `ADCS_CNT_ZERO;
      done   <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      done   <= nxt_done;
    end
  end

endmodule

// ### hw/adcs_top.sv
// Purpose: control and status registers of the 8-bit converter sequencer
// Assumes: analog result valid on conv_data_i when the timer expires
// Notes:   one clock; low power level comes from the mode controller
`timescale 1ns/1ps
`include "adcs_regs_regs.svh"

module adcs_top (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // operating mode
  input  wire logic       low_power_i,
  // analog front end
  input  wire logic [7:0] conv_data_i,
  output logic      [3:0] channel_select,
  output logic            analog_input_disable,
  output logic            ladder_on,
  output logic            sample_active,
  // interrupt
  output logic            conversion_done_irq
);

  logic                 rst_meta_ff;
  logic                 rst_sync_ff;
  adcs_pkg::adcs_ctrl1_t ctrl1_ff;
  adcs_pkg::adcs_ctrl1_t nxt_ctrl1;
  adcs_pkg::adcs_ctrl2_t ctrl2_ff;
  adcs_pkg::adcs_ctrl2_t nxt_ctrl2;
  adcs_pkg::adcs_state_t state_ff;
  adcs_pkg::adcs_state_t nxt_state;
  logic [7:0]           result_ff;
  logic [7:0]           nxt_result;
  logic                 eoc_ff;
  logic                 nxt_eoc;
  logic [7:0]           irq_stat_ff;
  logic [7:0]           nxt_irq_stat;
  logic [7:0]           irq_mask_ff;
  logic [7:0]           nxt_irq_mask;
  logic [7:0]           nxt_rdata;
  logic                 irq_ff;
  logic                 ladder_ff;
  logic                 sample_ff;
  logic                 tmr_done;
  logic [`ADCS_CT_W-1:0] conv_ticks;

  // conversion time code to cycle count; reserved codes fall to shortest
  function automatic logic [`ADCS_CT_W-1:0] ticks_of(input logic [2:0] c);
    logic [`ADCS_CT_W-1:0] t;
    t = `ADCS_CYC_39;
    if (c == `ADCS_CODE_78)   t = `ADCS_CYC_78;
    if (c == `ADCS_CODE_156)  t = `ADCS_CYC_156;
    if (c == `ADCS_CODE_312)  t = `ADCS_CYC_312;
    if (c == `ADCS_CODE_624)  t = `ADCS_CYC_624;
    if (c == `ADCS_CODE_1248) t = `ADCS_CYC_1248;
    return t;
  endfunction

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // address decode
  wire wr_ctrl1 = reg_wr && (reg_addr == `ADCS_OFF_CTRL1);
  wire wr_ctrl2 = reg_wr && (reg_addr == `ADCS_OFF_CTRL2);
  wire wr_istat = reg_wr && (reg_addr == `ADCS_OFF_IRQ_STAT);
  wire wr_imask = reg_wr && (reg_addr == `ADCS_OFF_IRQ_MASK);
  wire rd_res   = reg_rd && (reg_addr == `ADCS_OFF_RESULT);

  // start is taken one cycle after the write; low power blocks it
  wire start_go  = ctrl1_ff.start && !low_power_i;
  wire converting = (state_ff == adcs_pkg::ADCS_CONV);
  wire finish     = tmr_done && converting && !low_power_i;

  assign conv_ticks = ticks_of(ctrl2_ff.ctime);

  // control one: writes land whole, start bit drops once taken
  always_comb begin
    nxt_ctrl1 = ctrl1_ff;
    if (start_go) begin
      nxt_ctrl1.start = 1'b0;
    end
    if (wr_ctrl1) begin
      nxt_ctrl1 = adcs_pkg::adcs_ctrl1_t'(reg_wdata);
    end
    if (low_power_i) begin
      nxt_ctrl1 = adcs_pkg::adcs_ctrl1_t'(`ADCS_CTRL1_RST);
    end
  end

  // control two: plain storage, held at reset value in low power
  always_comb begin
    nxt_ctrl2 = ctrl2_ff;
    if (wr_ctrl2) begin
      nxt_ctrl2 = adcs_pkg::adcs_ctrl2_t'(reg_wdata);
    end
    if (low_power_i) begin
      nxt_ctrl2 = adcs_pkg::adcs_ctrl2_t'(`ADCS_CTRL2_RST);
    end
  end

  // sequencer: a restart while converting simply reloads the timer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      adcs_pkg::ADCS_IDLE: begin
        if (start_go) begin
          nxt_state = adcs_pkg::ADCS_CONV;
        end
      end
      adcs_pkg::ADCS_CONV: begin
        if (finish && !start_go) begin
          nxt_state = adcs_pkg::ADCS_IDLE;
        end
      end
    endcase
    if (low_power_i) begin
      nxt_state = adcs_pkg::ADCS_IDLE;
    end
  end

  // result keeps the old value across a restart until the new finish
  assign nxt_result = low_power_i ? `ADCS_BYTE_ZERO :
                      finish      ? conv_data_i : result_ff;

  // end flag: finish wins over both a result read and a restart
  assign nxt_eoc = finish ? 1'b1 :
                   (low_power_i || start_go || rd_res) ? 1'b0 :
                   eoc_ff;

  // sticky done event, write one to clear; a new event beats the clear
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_istat) begin
      nxt_irq_stat = irq_stat_ff & ~reg_wdata;
    end
    if (finish) begin
      nxt_irq_stat[`ADCS_IRQ_DONE_BIT] = 1'b1;
    end
  end

  assign nxt_irq_mask = wr_imask ? reg_wdata : irq_mask_ff;

  // read mux; meaningless bits read zero, data valid one cycle only
  wire [7:0] stat_word = {2'b00, eoc_ff, converting, 4'h0};
  wire [7:0] ctrl2_word = {2'b00, ctrl2_ff[5:0]};
  always_comb begin
    nxt_rdata = `ADCS_BYTE_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        `ADCS_OFF_CTRL1:    nxt_rdata = ctrl1_ff;
        `ADCS_OFF_CTRL2:    nxt_rdata = ctrl2_word;
        `ADCS_OFF_RESULT:   nxt_rdata = result_ff;
        `ADCS_OFF_STATUS:   nxt_rdata = stat_word;
        `ADCS_OFF_IRQ_STAT: nxt_rdata = irq_stat_ff;
        `ADCS_OFF_IRQ_MASK: nxt_rdata = irq_mask_ff;
        default:            nxt_rdata = `ADCS_BYTE_ZERO;
      endcase
    end
  end

  // ladder stays on permanently only when software asks for it
  wire nxt_ladder = !low_power_i &&
                    (ctrl2_ff.ladder || converting || start_go);
  wire nxt_irq    = |(nxt_irq_stat & nxt_irq_mask);

  // conversion timer
  adcs_timer u_timer (
    .clk   (clk),
    .rst_b (rst_sync_ff),
    .load  (start_go),
    .abort (low_power_i),
    .ticks (conv_ticks),
    .done  (tmr_done)
  );

  // register state
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ctrl1_ff    <= adcs_pkg::adcs_ctrl1_t'(`ADCS_CTRL1_RST);
      ctrl2_ff    <= adcs_pkg::adcs_ctrl2_t'(`ADCS_CTRL2_RST);
      state_ff    <= adcs_pkg::ADCS_IDLE;
      result_ff   <= `ADCS_BYTE_ZERO;
      eoc_ff      <= 1'b0;
      irq_stat_ff <= `ADCS_BYTE_ZERO;
      irq_mask_ff <= `ADCS_BYTE_ZERO;
    end else begin
      ctrl1_ff    <= nxt_ctrl1;
      ctrl2_ff    <= nxt_ctrl2;
      state_ff    <= nxt_state;
      result_ff   <= nxt_result;
      eoc_ff      <= nxt_eoc;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // output flops
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      reg_rdata <= `ADCS_BYTE_ZERO;
      irq_ff    <= 1'b0;
      ladder_ff <= 1'b0;
      sample_ff <= 1'b0;
    end else begin
      reg_rdata <= nxt_rdata;
      irq_ff    <= nxt_irq;
      ladder_ff <= nxt_ladder;
      sample_ff <= (nxt_state == adcs_pkg::ADCS_CONV);
    end
  end

  // pins taken straight from register flops
  assign channel_select       = ctrl1_ff.chan;
  assign analog_input_disable = ctrl1_ff.ain_dis;
  assign ladder_on            = ladder_ff;
  assign sample_active        = sample_ff;
  assign conversion_done_irq  = irq_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_ff);

  chk_start_clears: assert property (
    start_go && !wr_ctrl1 |=> !ctrl1_ff.start && converting)
    else $error("start bit not cleared or conversion not begun");

  chk_lp_reset: assert property (
    low_power_i |=> ctrl1_ff == adcs_pkg::adcs_ctrl1_t'(`ADCS_CTRL1_RST)
      && ctrl2_ff == adcs_pkg::adcs_ctrl2_t'(`ADCS_CTRL2_RST) && !converting)
    else $error("low power did not reset control state");

  chk_ladder_follow: assert property (
    !ctrl2_ff.ladder && !converting && !start_go |=> !ladder_on)
    else $error("ladder connected while idle without request");

  property p_time_39;
    @(posedge clk) disable iff (!rst_sync_ff || low_power_i)
    start_go && ctrl2_ff.ctime == `ADCS_CODE_39 && !converting
      |-> ##40 tmr_done;
  endproperty
  chk_time_short: assert property (p_time_39)
    else $error("shortest conversion time wrong");

  chk_eoc_set: assert property (
    finish |=> eoc_ff && !converting)
    else $error("end flag missing after finish");

  chk_eoc_readclr: assert property (
    rd_res && !finish |=> !eoc_ff)
    else $error("result read left end flag set");

  chk_busy_start: assert property (
    !converting && start_go |=> stat_word[`ADCS_STAT_BUSY_BIT])
    else $error("busy flag not set at start");

  chk_result_store: assert property (
    finish |=> result_ff == $past(conv_data_i))
    else $error("result not stored at finish");

  chk_irq_done: assert property (
    finish |=> irq_stat_ff[`ADCS_IRQ_DONE_BIT] && eoc_ff)
    else $error("done interrupt not raised with end flag");

  chk_restart_keep: assert property (
    start_go && !finish && !low_power_i |=> !eoc_ff
      && result_ff == $past(result_ff))
    else $error("restart disturbed result or end flag");

  chk_stat_zero: assert property (
    reg_rd && reg_addr == `ADCS_OFF_STATUS |=> reg_rdata[3:0] == 4'h0
      && reg_rdata[7:6] == 2'b00)
    else $error("status filler bits not zero");

  // longest conversion ends and its result is read soon after
  cov_full_conv: cover property (
    finish && ctrl2_ff.ctime == `ADCS_CODE_1248 ##[1:20] rd_res);
  cov_restart:   cover property (finish ##[1:100] start_go && eoc_ff);
  cov_lp_abort:  cover property (converting && low_power_i);

endmodule
